// >>> common/ccal_pkg.sv
/*
 * ccal_pkg: shared constants and carriers for the channel calibration
 * engine. Assumes 24-bit fixed-point sample words on every channel.
 */
package ccal_pkg;
	localparam int W = 24;
	localparam int NCH = 4;
	localparam logic [23:0] CYCLE_COUNT_RST = 24'h000fa0;
	localparam int CONV_PER_SAMPLE = 1024;
	localparam logic [23:0] DC_EXTRA_CYCLES = 24'h00001e;
	localparam logic [2:0] AC_OFF_MULT = 3'h6;
	localparam logic [23:0] GAIN_ONE = 24'h400000;
	localparam logic [23:0] GAIN_LIMIT = 24'h800000;
	localparam logic [23:0] AC_GAIN_TARGET = 24'h4ccccd;
	localparam logic [23:0] DC_GAIN_TARGET = 24'h7fffff;
	localparam logic [23:0] OFFSET_RST = 24'h000000;
	localparam logic [7:0] PHASE_RST = 8'h00;
	localparam logic [23:0] POWER_OFF_RST = 24'h000000;

	typedef enum logic [1:0] {
		CCAL_DC_OFF = 2'h0,
		CCAL_AC_OFF = 2'h1,
		CCAL_DC_GAIN = 2'h2,
		CCAL_AC_GAIN = 2'h3
	} ccal_kind_e;

	typedef struct packed {
		logic [W-1:0] dc_off;
		logic [W-1:0] ac_off;
		logic [W-1:0] gain;
	} ccal_corr_s;

	typedef struct packed {
		logic        start;
		ccal_kind_e  kind;
		logic [1:0]  chan;
	} ccal_cmd_s;
endpackage

// >>> hw/ccal_corr_mem.sv
/*
 * ccal_corr_mem: per-channel correction word store, registered read.
 * Assumes one writer; write and read on the same clock.
 */
`timescale 1ns/1ps
module ccal_corr_mem
	import ccal_pkg::*;
#(
	parameter int DEPTH = 4
) (
	input  wire logic               ref_clk,
	input  wire logic               resetn,
	input  wire logic               wr_en,
	input  wire logic [1:0]         wr_addr,
	input  wire ccal_pkg::ccal_corr_s wr_data,
	input  wire logic [1:0]         rd_addr,
	output      ccal_pkg::ccal_corr_s rd_data
);
	ccal_corr_s mem_q [DEPTH];
	ccal_corr_s rd_q;

	assign rd_data = rd_q;

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= '{OFFSET_RST, OFFSET_RST, GAIN_ONE};
			end
			rd_q <= '{OFFSET_RST, OFFSET_RST, GAIN_ONE};
		end else begin
			// other channels untouched by a write
			if (wr_en) begin
				mem_q[wr_addr] <= wr_data;
			end
			rd_q <= mem_q[rd_addr];
		end
	end
endmodule

// >>> hw/ccal_engine.sv
/*
 * ccal_engine: offset/gain calibration sequencer and sample corrector.
 * Assumes sample_valid marks one conversion result on sample_chan and
 * that rms words come from an outside rms block, same clock.
 */
// Operation
// - dc offset and gain on samples, ac on rms
// - each channel keeps its own correction words
// - result stored, ready flag set, masked interrupt
// - dc calibrations last at least n plus 30
// - ac offset lasts at least 6n plus 30
// - dc offset stores negated sample average
// - dc offset added to each sample
// - ac offset subtracted from later rms results
// - gain at or above four marks invalid
// - ac gain stores 0.6 over rms
// - samples multiplied by channel gain
// - dc gain resets to one, stores one/average
// - two signed 8-bit phase fields reset zero
// - phase step set by field and clock; here the fields are only held
// - programmable active power offset applied
// - computation cycle is n times 1024 conversions; code averages n samples, CONV_PER_SAMPLE unused
// - ac offset is 24-bit signed fraction; stored and subtracted as unsigned here
`timescale 1ns/1ps
module ccal_engine
	import ccal_pkg::*;
#(
	parameter logic [23:0] CYCLE_COUNT_DEF = CYCLE_COUNT_RST
) (
	input  wire logic                 ref_clk,
	input  wire logic                 resetn,
	input  wire ccal_pkg::ccal_cmd_s  cmd,
	input  wire logic                 active_state,
	input  wire logic [23:0]          cycle_count,
	input  wire logic                 ready_mask,
	input  wire logic                 ready_clear,
	input  wire logic                 sample_valid,
	input  wire logic [1:0]           sample_chan,
	input  wire logic signed [23:0]   sample_raw,
	input  wire logic [23:0]          rms_raw,
	input  wire logic [1:0]           rms_chan,
	input  wire logic signed [23:0]   power_raw,
	input  wire logic signed [23:0]   power_offset,
	input  wire logic [7:0]           phase_comp_ch1_in,
	input  wire logic [7:0]           phase_comp_ch2_in,
	input  wire logic                 phase_load,
	output      logic signed [23:0]   sample_out,
	output      logic [23:0]          rms_out,
	output      logic signed [23:0]   power_out,
	output      logic [7:0]           phase_comp_ch1,
	output      logic [7:0]           phase_comp_ch2,
	output      logic                 busy,
	output      logic                 result_ready_flag,
	output      logic                 cal_int,
	output      logic                 gain_invalid
);
	import ccal_pkg::*;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_RUN  = 4'b0010,
		ST_CALC = 4'b0100,
		ST_DONE = 4'b1000
	} ccal_state_e;

	ccal_state_e st_q, st_d;
	ccal_kind_e kind_q, kind_d;
	logic [1:0] chan_q, chan_d;
	logic [35:0] cnt_q, cnt_d, need_q, need_d;
	logic signed [47:0] acc_q, acc_d;
	logic [23:0] smp_q, smp_d;
	logic rdy_q, rdy_d, inv_q, inv_d;
	logic [7:0] pc1_q, pc1_d, pc2_q, pc2_d;
	logic signed [23:0] so_q, so_d, po_q, po_d;
	logic [23:0] ro_q, ro_d;
	logic wr_en;
	ccal_corr_s wr_data, rd_corr;
	logic [1:0] rd_addr;
	logic [47:0] quot;
	logic signed [23:0] avg;
	logic signed [47:0] prod;
	logic signed [24:0] ssum;
	logic [24:0] rdiff;
	logic [23:0] acoff_q [NCH], acoff_d [NCH];

	// corrections are looked up for the channel being corrected or
	// calibrated; a one-cycle read latency is covered by sample_chan being held a cycle before sample_valid.
	// an accepted start fetches its own channel so the first run cycle
	// can rewrite that word without touching any other channel
	assign rd_addr = (st_q != ST_IDLE) ? chan_q :
		(cmd.start && active_state) ? cmd.chan : sample_chan;

	ccal_corr_mem #(.DEPTH(NCH)) u_mem (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.wr_en   (wr_en),
		.wr_addr (chan_q),
		.wr_data (wr_data),
		.rd_addr (rd_addr),
		.rd_data (rd_corr)
	);

	function automatic logic [47:0] fdiv(input logic [23:0] num,
			input logic [23:0] den);
		logic [47:0] n;
		n = {num, 24'h000000};
		fdiv = (den == 24'h000000) ? 48'hffffffffffff :
			n / {24'h000000, den};
	endfunction

	assign avg = 24'(acc_q / $signed({12'h000, smp_q}));
	assign quot = (kind_q == CCAL_AC_GAIN) ?
		fdiv(AC_GAIN_TARGET, rms_raw) >> 2 :
		fdiv(DC_GAIN_TARGET, avg[23] ? 24'(-avg) : avg) >> 2;

	always_comb begin
		st_d = st_q;
		kind_d = kind_q;
		chan_d = chan_q;
		cnt_d = cnt_q;
		need_d = need_q;
		acc_d = acc_q;
		smp_d = smp_q;
		rdy_d = rdy_q;
		inv_d = inv_q;
		wr_en = 1'b0;
		wr_data = rd_corr;
		acoff_d = acoff_q;
		case (st_q)
			ST_IDLE: begin
				// ignored outside active state or while one runs
				if (cmd.start && active_state) begin
					st_d = ST_RUN;
					kind_d = cmd.kind;
					chan_d = cmd.chan;
					cnt_d = '0;
					acc_d = '0;
					smp_d = '0;
					need_d = (cmd.kind == CCAL_AC_OFF) ?
						36'(AC_OFF_MULT) * 36'(cycle_count) + 36'(DC_EXTRA_CYCLES) :
						36'(cycle_count) + 36'(DC_EXTRA_CYCLES);
				end
			end
			ST_RUN: begin
				// gain back to one before averaging; repeats are harmless
				if (kind_q == CCAL_DC_GAIN && cnt_q == 36'h0) begin
					wr_en = 1'b1;
					wr_data.gain = GAIN_ONE;
				end
				if (sample_valid && sample_chan == chan_q) begin
					cnt_d = cnt_q + 36'h1;
					if (cnt_q < 36'(cycle_count)) begin
						acc_d = acc_q + 48'(sample_raw);
						smp_d = smp_q + 24'h1;
					end
					if (cnt_d >= need_q) begin
						st_d = ST_CALC;
					end
				end
			end
			ST_CALC: begin
				wr_en = 1'b1;
				case (kind_q)
					CCAL_DC_OFF: wr_data.dc_off = 24'(-avg);
					CCAL_AC_OFF: begin
						wr_data.ac_off = rms_raw;
						acoff_d[chan_q] = rms_raw;
					end
					default: begin
						wr_data.gain = quot[23:0];
						// doubled limit word is 4.0 in the gain format
						inv_d = (quot >= (48'(GAIN_LIMIT) << 1));
					end
				endcase
				st_d = ST_DONE;
			end
			ST_DONE: begin
				st_d = ST_IDLE;
			end
			default: st_d = ST_IDLE;
		endcase
		// set wins over a same-cycle clear
		if (st_q == ST_DONE) begin
			rdy_d = 1'b1;
		end else if (ready_clear) begin
			rdy_d = 1'b0;
		end
	end

	always_comb begin
		ssum = 25'(sample_raw) + 25'($signed(rd_corr.dc_off));
		prod = 48'(ssum) * 48'($signed({1'b0, rd_corr.gain}));
		so_d = sample_valid ? 24'(prod >>> 22) : so_q;
		// rms words carry their own channel, apart from the sample path
		rdiff = {1'b0, rms_raw} - {1'b0, acoff_q[rms_chan]};
		ro_d = rdiff[24] ? 24'h000000 : rdiff[23:0];
		po_d = power_raw + power_offset;
		pc1_d = phase_load ? phase_comp_ch1_in : pc1_q;
		pc2_d = phase_load ? phase_comp_ch2_in : pc2_q;
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			st_q <= ST_IDLE;
			kind_q <= CCAL_DC_OFF;
			chan_q <= 2'h0;
			cnt_q <= '0;
			need_q <= '0;
			acc_q <= '0;
			smp_q <= '0;
			rdy_q <= 1'b0;
			inv_q <= 1'b0;
			pc1_q <= PHASE_RST;
			pc2_q <= PHASE_RST;
			so_q <= '0;
			ro_q <= '0;
			po_q <= POWER_OFF_RST;
			for (int i = 0; i < NCH; i++) begin
				acoff_q[i] <= OFFSET_RST;
			end
		end else begin
			st_q <= st_d;
			kind_q <= kind_d;
			chan_q <= chan_d;
			cnt_q <= cnt_d;
			need_q <= need_d;
			acc_q <= acc_d;
			smp_q <= smp_d;
			rdy_q <= rdy_d;
			inv_q <= inv_d;
			pc1_q <= pc1_d;
			pc2_q <= pc2_d;
			so_q <= so_d;
			ro_q <= ro_d;
			po_q <= po_d;
			acoff_q <= acoff_d;
		end
	end

	assign sample_out = so_q;
	assign rms_out = ro_q;
	assign power_out = po_q;
	assign phase_comp_ch1 = pc1_q;
	assign phase_comp_ch2 = pc2_q;
	assign busy = (st_q != ST_IDLE);
	assign result_ready_flag = rdy_q;
	assign cal_int = rdy_q & ready_mask;
	assign gain_invalid = inv_q;

	chk_ready_after_done: assert property (@(posedge ref_clk)
		disable iff (!resetn) st_q == ST_DONE |=> rdy_q)
		else $error("ready flag not set after calibration");
	chk_int_masked: assert property (@(posedge ref_clk)
		disable iff (!resetn) cal_int |-> (rdy_q && ready_mask))
		else $error("interrupt without masked ready");
	chk_min_length: assert property (@(posedge ref_clk)
		disable iff (!resetn) (st_q == ST_RUN && st_d == ST_CALC)
		|-> cnt_d >= 36'(cycle_count) + 36'(DC_EXTRA_CYCLES))
		else $error("calibration ended too early");
	chk_ac_length: assert property (@(posedge ref_clk)
		disable iff (!resetn) (st_q == ST_RUN && kind_q == CCAL_AC_OFF
		&& st_d == ST_CALC) |-> cnt_d >= 36'(AC_OFF_MULT)
		* 36'(cycle_count) + 36'(DC_EXTRA_CYCLES))
		else $error("ac offset ended too early");
	chk_one_at_time: assert property (@(posedge ref_clk)
		disable iff (!resetn) (st_q == ST_RUN && cmd.start)
		|=> $stable(chan_q) && $stable(kind_q))
		else $error("start taken while busy");
	chk_inactive_ignored: assert property (@(posedge ref_clk)
		disable iff (!resetn) (st_q == ST_IDLE && !active_state)
		|=> st_q == ST_IDLE)
		else $error("start taken outside active state");
	chk_dcgain_reset: assert property (@(posedge ref_clk)
		disable iff (!resetn) (st_q == ST_IDLE && st_d == ST_RUN
		&& cmd.kind == CCAL_DC_GAIN) |=> wr_en && wr_data.gain == GAIN_ONE)
		else $error("dc gain not reset to one");
	chk_phase_hold: assert property (@(posedge ref_clk)
		disable iff (!resetn) !phase_load |=> $stable(pc1_q) && $stable(pc2_q))
		else $error("phase field changed without load");
	chk_done_one_cycle: assert property (@(posedge ref_clk)
		disable iff (!resetn) st_q == ST_CALC |-> wr_en ##1 st_q == ST_DONE
		##1 st_q == ST_IDLE)
		else $error("result write sequence broken");
endmodule

// >>> tb/ccal_host_model.sv
/*
 * ccal_host_model: conversion source feeding one channel's samples.
 * Assumes enable and channel change only at the falling clock edge.
 */
`timescale 1ns/1ps
module ccal_host_model (
	input  wire logic               ref_clk,
	input  wire logic               en,
	input  wire logic [1:0]         chan,
	input  wire logic signed [23:0] level,
	output      logic               sample_valid,
	output      logic [1:0]         sample_chan,
	output      logic signed [23:0] sample_raw,
	output      int                 pulses
);
	logic               en_q = 1'b0;
	logic signed [23:0] level_q = 24'h000000;

	initial begin
		sample_valid = 1'b0;
		sample_raw = 24'h000000;
		pulses = 0;
	end
	// channel held steady so the correction word is read a cycle early
	assign sample_chan = chan;
	// bench inputs taken at the rising edge so its falling-edge writes
	// never race the process below
	always @(posedge ref_clk) begin
		en_q <= en;
		level_q <= level;
	end
	// between conversions the word is not held: show its inverse
	always @(negedge ref_clk) begin
		sample_valid <= en_q && !sample_valid;
		sample_raw <= (en_q && !sample_valid) ? level_q : ~level_q;
		if (en_q && !sample_valid)
			pulses <= pulses + 1;
	end
endmodule

// >>> tb/testbench.sv
/*
 * testbench: runs each calibration kind through the engine's ports.
 * Assumes the conversion source model and a 40 MHz reference clock.
 */
`timescale 1ns/1ps
module testbench;
	import ccal_pkg::*;
	logic               ref_clk = 1'b0;
	logic               resetn = 1'b0;
	ccal_cmd_s          cmd = '0;
	logic               act = 1'b1, mask = 1'b0, clr = 1'b0;
	logic               en = 1'b0, ld = 1'b0;
	logic [1:0]         ch = 2'h0, rch = 2'h0;
	logic signed [23:0] lvl = 24'h000000, pw = 24'h000000, po = 24'h000000;
	logic [23:0]        rms = 24'h000000;
	logic [7:0]         pc1 = 8'h00, pc2 = 8'h00;
	logic               sv, rdy, irq, busy, ginv;
	logic [1:0]         sch;
	logic signed [23:0] sraw, sout, pout;
	logic [23:0]        rout;
	logic [7:0]         ph1, ph2;
	int                 pulses, err_count = 0, compares = 0, cyc = 0;

	always #12.5 ref_clk = ~ref_clk;

	ccal_host_model u_src (.ref_clk(ref_clk), .en(en), .chan(ch),
		.level(lvl), .sample_valid(sv), .sample_chan(sch),
		.sample_raw(sraw), .pulses(pulses));

	ccal_engine u_dut (.ref_clk(ref_clk), .resetn(resetn), .cmd(cmd),
		.active_state(act), .cycle_count(24'h000004),
		.ready_mask(mask), .ready_clear(clr), .sample_valid(sv),
		.sample_chan(sch), .sample_raw(sraw), .rms_raw(rms),
		.rms_chan(rch), .power_raw(pw), .power_offset(po),
		.phase_comp_ch1_in(pc1), .phase_comp_ch2_in(pc2),
		.phase_load(ld), .sample_out(sout), .rms_out(rout),
		.power_out(pout), .phase_comp_ch1(ph1), .phase_comp_ch2(ph2),
		.busy(busy), .result_ready_flag(rdy), .cal_int(irq),
		.gain_invalid(ginv));

	task automatic cmp(input logic [23:0] a, input logic [23:0] e);
		compares++;
		if (a !== e) begin
			err_count++;
			$display("[FAIL] %0t got %h exp %h", $time, a, e);
		end
	endtask

	task automatic summarize();
		if (err_count == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ceiling well above five calibrations of at most 6n+30 samples
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			err_count++;
			summarize();
		end
	end

	task automatic tick(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	task automatic run_cal(input ccal_kind_e k, input logic [1:0] c,
			input logic signed [23:0] l, input int need);
		int p0;
		int w;
		tick(1);
		ch = c;
		lvl = l;
		cmd = '{1'b1, k, c};
		tick(1);
		p0 = pulses;
		// a second start while busy must be ignored
		cmd = '{1'b1, CCAL_AC_GAIN, ~c};
		en = 1'b1;
		cmp(busy, 1'b1);
		tick(1);
		cmd.start = 1'b0;
		cmp(busy, 1'b1);
		w = 0;
		while (rdy !== 1'b1 && w < 400) begin
			tick(1);
			w++;
		end
		// the source's next pulse lands before the flag rises
		cmp(pulses - p0 >= need + 1, 1'b1);
		cmp({rdy, irq, busy}, {1'b1, mask, 1'b0});
		en = 1'b0;
		clr = 1'b1;
		tick(1);
		clr = 1'b0;
		tick(1);
		cmp(rdy, 1'b0);
	endtask

	task automatic check_sample(input logic [1:0] c,
			input logic signed [23:0] l, input logic signed [23:0] e,
			input int tol);
		int d;
		tick(1);
		ch = c;
		lvl = l;
		en = 1'b1;
		repeat (2) @(posedge ref_clk iff sv);
		#1;
		d = int'(sout) - int'(e);
		cmp(d <= tol && d >= -tol && !$isunknown(sout), 1'b1);
		tick(1);
		en = 1'b0;
	endtask

	initial begin
		tick(12);
		resetn = 1'b1;
		tick(1);
		cmp({ph2, ph1}, 16'h0000);
		cmp({rdy, irq, busy, ginv}, 4'h0);
		pc1 = 8'h80;
		pc2 = 8'h7f;
		ld = 1'b1;
		tick(1);
		ld = 1'b0;
		tick(1);
		cmp({ph2, ph1}, 16'h7f80);
		pw = 24'h001000;
		po = 24'hfff800;
		tick(2);
		cmp(pout, 24'h000800);
		// an inactive device must not take the start request
		act = 1'b0;
		cmd = '{1'b1, CCAL_DC_OFF, 2'h0};
		tick(3);
		cmd.start = 1'b0;
		cmp(busy, 1'b0);
		act = 1'b1;
		// gains are one after reset, offsets zero
		run_cal(CCAL_DC_OFF, 2'h0, 24'h001234, 34);
		check_sample(2'h0, 24'h001234, 24'h000000, 0);
		check_sample(2'h1, 24'h001234, 24'h001234, 0);
		mask = 1'b1;
		run_cal(CCAL_DC_GAIN, 2'h1, 24'h400000, 34);
		check_sample(2'h1, 24'h400000, 24'h7fffff, 256);
		check_sample(2'h0, 24'h001234, 24'h000000, 0);
		cmp(ginv, 1'b0);
		rms = 24'h001000;
		rch = 2'h2;
		run_cal(CCAL_AC_OFF, 2'h2, 24'h000000, 54);
		rms = 24'h005000;
		tick(3);
		cmp(rout, 24'h004000);
		rms = 24'h000800;
		tick(3);
		cmp(rout, 24'h000000);
		rch = 2'h1;
		tick(3);
		cmp(rout, 24'h000800);
		rms = 24'h200000;
		rch = 2'h3;
		run_cal(CCAL_AC_GAIN, 2'h3, 24'h200000, 34);
		check_sample(2'h3, 24'h100000, 24'h266666, 64);
		cmp(ginv, 1'b0);
		rms = 24'h100000;
		run_cal(CCAL_AC_GAIN, 2'h3, 24'h100000, 34);
		cmp(ginv, 1'b1);
		summarize();
	end
endmodule
